// ### core/dmareq_core.sv
// DMA transfer request front end: eight channels, APB registers, request pins
//
// Behaviour
// R1: A transfer starts only for a request after start, and only under bus grant.
// R2: External select 0 plus start raises an internal request at once.
// R3: Internal request holds until the channel completes; units follow back to back.
// R4: Internal request channels accept memory-to-memory setup only.
// R5: External select 1 plus start puts the channel in standby awaiting a request.
// R6: Controller request is low level; pin request is falling edge or low level.
// R7: Each acknowledged request moves one unit of 32, 16 or 8 bits.
// R8: Acknowledge clears controller request; per I/O unit, or at count zero.
// R9: A withdrawn controller request may still yield one transfer.
// R10: Two pin requests route from port F or port J; port F wins.
// R11: Requester re-creates an edge per request, or holds level for more.
// R12: Pin memory-to-memory uses level mode; pin I/O transfers use edge mode.
// R13: Level mode samples each clock; low in standby starts transfer.
// R14: Polarity bit 13 at 0 selects active-low request.
// R15: Edge detection needs level bit 12 at 0.
// R16: Acknowledge output is active low like the request.
// R17: Level requester holds low until acknowledge, else request may be lost.
// R18: Level mode line not low means no request; channel returns to standby.
// R19: Falling edge is low now after not-low at the previous clock edge.
// R20: Edge seen after acknowledge gives the next unit with no gap.
// R21: No edge after acknowledge means no request; channel returns to standby.
// R22: Pin requests pass a two-stage synchroniser before evaluation.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "dmareq_params.svh"

module dmareq_core #(
    parameter int NUM_CH = `DMAREQ_NUM_CH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Request sources
    input wire logic [7:0] i_interrupt_controller_dma_request_n,
    input wire logic [1:0] i_port_f_ext_dma_request_n,
    input wire logic [1:0] i_port_j_ext_dma_request_n,
    // Transfer engine handshake
    output logic [7:0] o_bus_request,
    input wire logic [7:0] i_bus_grant,
    input wire logic [7:0] i_unit_done,
    // Acknowledge pins
    output logic [7:0] o_dma_acknowledge_n
);
    import dmareq_pkg::*;

    dmareq_state_t cur;
    dmareq_state_t next_cur;

    logic setup;
    logic wr_en;
    logic [7:0] ch_line_low;
    logic [7:0] ch_has_pin;
    logic [1:0] pin_low;

    assign setup = i_psel && !i_penable;
    assign wr_en = i_psel && i_penable && i_pwrite;

    // Port F takes the line whenever both ports hand the pin to the DMA
    always_comb begin
        for (int p = 0; p < `DMAREQ_NUM_PIN; p++) begin
            if (cur.port_f_fn[p]) begin
                pin_low[p] = !cur.sync2[p]; // see R10 see R22
            end else if (cur.port_j_fn[p]) begin
                pin_low[p] = !cur.sync2[p + 2]; // see R10
            end else begin
                pin_low[p] = 1'b0;
            end
        end
    end

    // Pins can feed channels 2 and 3; the controller line feeds every channel not set to pin source
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            ch_has_pin[c] = (c == 2) || (c == 3);
            if (ch_has_pin[c] && cur.ccr[c][`DMAREQ_CCR_PIN_SRC]) begin
                ch_line_low[c] = (c == 2) ? pin_low[0] : pin_low[1];
            end else begin
                ch_line_low[c] = !i_interrupt_controller_dma_request_n[c]; // see R6
            end
            // Polarity bit set flips the sense to active high
            if (cur.ccr[c][`DMAREQ_CCR_POL]) begin
                ch_line_low[c] = !ch_line_low[c]; // see R14
            end
        end
    end

    always_comb begin
        logic [7:0] ofs;
        logic [3:0] reg_sel;
        logic [2:0] ch;
        logic [23:0] unit;
        logic [23:0] left;
        logic is_pin;
        logic edge_mode;
        logic ok;
        logic req_now;
        ofs = i_paddr[11:4] == 8'h00 ? 8'h00 : i_paddr[11:4];
        reg_sel = i_paddr[3:0];
        ch = i_paddr[6:4];
        unit = 24'h000000;
        left = 24'h000000;
        is_pin = 1'b0;
        edge_mode = 1'b0;
        ok = 1'b0;
        req_now = 1'b0;
        next_cur = cur;

        next_cur.sync1 = {i_port_j_ext_dma_request_n, i_port_f_ext_dma_request_n};
        next_cur.sync2 = cur.sync1; // see R22

        // APB read data and error are caught in the setup cycle
        if (setup) begin
            next_cur.rdata = 32'h00000000;
            next_cur.slverr = 1'b0;
            if (i_paddr == {4'h0, `DMAREQ_OFS_PORTFN}) begin
                next_cur.rdata = {28'h0000000, cur.port_j_fn, cur.port_f_fn};
            end else if (i_paddr[11:7] == 5'h00 && reg_sel == `DMAREQ_OFS_CCR) begin
                next_cur.rdata = {16'h0000, cur.ccr[ch]};
                next_cur.rdata[`DMAREQ_CCR_START] = cur.chan[ch] != DMAREQ_IDLE;
            end else if (i_paddr[11:7] == 5'h00 && reg_sel == `DMAREQ_OFS_BCR) begin
                next_cur.rdata = {8'h00, cur.bcr[ch]};
            end else if (i_paddr[11:7] == 5'h00 && reg_sel == `DMAREQ_OFS_STAT) begin
                next_cur.rdata[`DMAREQ_STAT_ACTIVE] = cur.chan[ch] != DMAREQ_IDLE;
                next_cur.rdata[`DMAREQ_STAT_DONE] = cur.done[ch];
                next_cur.rdata[`DMAREQ_STAT_CFGERR] = cur.cfgerr[ch];
                next_cur.rdata[`DMAREQ_STAT_STANDBY] = cur.chan[ch] == DMAREQ_STANDBY;
            end else begin
                next_cur.slverr = 1'b1;
            end
        end

        for (int c = 0; c < 8; c++) begin
            next_cur.ack_n[c] = 1'b1;
            is_pin = ch_has_pin[c] && cur.ccr[c][`DMAREQ_CCR_PIN_SRC];
            edge_mode = is_pin && !cur.ccr[c][`DMAREQ_CCR_LEVEL]; // see R15
            // Unit in bytes from the two-bit size field
            case (cur.ccr[c][`DMAREQ_CCR_SIZE_HI:`DMAREQ_CCR_SIZE_LO])
                2'b10: unit = 24'h000002;
                2'b11: unit = 24'h000001;
                default: unit = 24'h000004; // see R7
            endcase

            // Falling edge: low now, not low at the previous edge
            next_cur.prev_low[c] = ch_line_low[c];
            if (ch_line_low[c] && !cur.prev_low[c] && cur.chan[c] != DMAREQ_IDLE) begin
                next_cur.edge_pend[c] = 1'b1; // see R19
            end

            case (cur.chan[c])
                DMAREQ_STANDBY: begin
                    req_now = edge_mode ? cur.edge_pend[c] : ch_line_low[c]; // see R13
                    if (req_now) begin
                        next_cur.chan[c] = DMAREQ_XFER; // see R5 see R6
                        if (edge_mode) begin
                            next_cur.edge_pend[c] = 1'b0;
                        end
                    end
                end
                DMAREQ_XFER: begin
                    // A unit counts only while the bus is ours
                    if (i_bus_grant[c] && i_unit_done[c]) begin // see R1
                        left = cur.bcr[c] > unit ? cur.bcr[c] - unit : 24'h000000;
                        next_cur.bcr[c] = left; // see R7
                        if (cur.ccr[c][`DMAREQ_CCR_IO] || left == 24'h000000) begin
                            next_cur.ack_n[c] = 1'b0; // see R8 see R16
                        end
                        if (left == 24'h000000) begin
                            next_cur.chan[c] = DMAREQ_IDLE;
                            next_cur.done[c] = 1'b1;
                        end else if (!cur.ccr[c][`DMAREQ_CCR_EXT_SEL]) begin
                            next_cur.chan[c] = DMAREQ_XFER; // see R3
                        end else if (edge_mode) begin
                            // Edge after acknowledge keeps going with no gap
                            if (cur.edge_pend[c] || (ch_line_low[c] && !cur.prev_low[c])) begin
                                next_cur.edge_pend[c] = 1'b0; // see R20
                            end else begin
                                next_cur.chan[c] = DMAREQ_STANDBY; // see R21
                            end
                        end else if (!cur.ccr[c][`DMAREQ_CCR_IO] || is_pin) begin
                            // Memory copy by level: line still low keeps going
                            if (!ch_line_low[c]) begin
                                next_cur.chan[c] = DMAREQ_STANDBY; // see R18
                            end
                        end else begin
                            // Controller I/O: one unit per request, acknowledge clears it
                            next_cur.chan[c] = DMAREQ_STANDBY; // see R8 see R9
                        end
                    end
                end
                DMAREQ_IDLE: begin
                end
                default: begin
                    next_cur.chan[c] = DMAREQ_IDLE;
                end
            endcase

            // Register writes take effect in the access cycle
            if (wr_en && i_paddr[11:7] == 5'h00 && ch == c[2:0]) begin
                if (reg_sel == `DMAREQ_OFS_BCR && cur.chan[c] == DMAREQ_IDLE) begin
                    next_cur.bcr[c] = i_pwdata[23:0];
                end
                if (reg_sel == `DMAREQ_OFS_STAT) begin
                    // Write one to clear; a completion in the same cycle still sets the flag
                    next_cur.done[c] = next_cur.done[c]
                        && !(cur.done[c] && i_pwdata[`DMAREQ_STAT_DONE]);
                    next_cur.cfgerr[c] = cur.cfgerr[c] && !i_pwdata[`DMAREQ_STAT_CFGERR];
                end
                if (reg_sel == `DMAREQ_OFS_CCR) begin
                    if (cur.chan[c] == DMAREQ_IDLE) begin
                        next_cur.ccr[c] = i_pwdata[15:0] & `DMAREQ_CCR_MASK;
                    end
                    if (!i_pwdata[`DMAREQ_CCR_START]) begin
                        // Clearing start abandons the channel
                        next_cur.chan[c] = DMAREQ_IDLE;
                    end else if (cur.chan[c] == DMAREQ_IDLE) begin
                        is_pin = ch_has_pin[c] && i_pwdata[`DMAREQ_CCR_PIN_SRC];
                        ok = !cur.done[c] && !cur.cfgerr[c] && cur.bcr[c] != 24'h000000;
                        if (!i_pwdata[`DMAREQ_CCR_EXT_SEL] && i_pwdata[`DMAREQ_CCR_IO]) begin
                            ok = 1'b0; // see R4
                        end
                        if (is_pin && i_pwdata[`DMAREQ_CCR_EXT_SEL]
                                && (i_pwdata[`DMAREQ_CCR_IO] == i_pwdata[`DMAREQ_CCR_LEVEL])) begin
                            ok = 1'b0; // see R12
                        end
                        if (!ok) begin
                            next_cur.cfgerr[c] = 1'b1;
                        end else if (!i_pwdata[`DMAREQ_CCR_EXT_SEL]) begin
                            next_cur.chan[c] = DMAREQ_XFER; // see R2
                        end else begin
                            next_cur.chan[c] = DMAREQ_STANDBY; // see R5
                            // Edges older than the start do not count
                            next_cur.edge_pend[c] = 1'b0; // see R1
                        end
                    end
                end
            end
        end

        if (wr_en && i_paddr == {4'h0, `DMAREQ_OFS_PORTFN}) begin
            next_cur.port_f_fn = i_pwdata[1:0];
            next_cur.port_j_fn = i_pwdata[3:2];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int c = 0; c < 8; c++) begin
                cur.chan[c] <= DMAREQ_IDLE;
                cur.ccr[c] <= `DMAREQ_CCR_RST;
                cur.bcr[c] <= `DMAREQ_BCR_RST;
            end
            cur.done <= 8'h00;
            cur.cfgerr <= 8'h00;
            cur.edge_pend <= 8'h00;
            cur.prev_low <= 8'h00;
            cur.ack_n <= 8'hFF;
            cur.sync1 <= 4'hF;
            cur.sync2 <= 4'hF;
            cur.port_f_fn <= 2'h0;
            cur.port_j_fn <= 2'h0;
            cur.rdata <= 32'h00000000;
            cur.slverr <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    always_comb begin
        for (int c = 0; c < 8; c++) begin
            o_bus_request[c] = cur.chan[c] == DMAREQ_XFER; // see R1
        end
    end

    assign o_dma_acknowledge_n = cur.ack_n;
    assign o_prdata = cur.rdata;
    assign o_pslverr = cur.slverr && i_psel && i_penable;
    assign o_pready = 1'b1;

endmodule : dmareq_core

// ### core/dmareq_params.svh
// Register offsets, field positions and reset values of the DMA request front end
`ifndef DMAREQ_PARAMS_SVH
`define DMAREQ_PARAMS_SVH

`define DMAREQ_NUM_CH 8
`define DMAREQ_NUM_PIN 2
`define DMAREQ_BCR_W 24
`define DMAREQ_CCR_W 16

`define DMAREQ_CH_STRIDE 8'h10
`define DMAREQ_OFS_CCR 4'h0
`define DMAREQ_OFS_BCR 4'h4
`define DMAREQ_OFS_STAT 4'h8
`define DMAREQ_OFS_PORTFN 8'h80

`define DMAREQ_CCR_START 0
`define DMAREQ_CCR_EXT_SEL 1
`define DMAREQ_CCR_SIZE_LO 2
`define DMAREQ_CCR_SIZE_HI 3
`define DMAREQ_CCR_IO 4
`define DMAREQ_CCR_PIN_SRC 5
`define DMAREQ_CCR_LEVEL 12
`define DMAREQ_CCR_POL 13
`define DMAREQ_CCR_MASK 16'h303E

`define DMAREQ_STAT_ACTIVE 0
`define DMAREQ_STAT_DONE 1
`define DMAREQ_STAT_CFGERR 2
`define DMAREQ_STAT_STANDBY 3

`define DMAREQ_CCR_RST 16'h0000
`define DMAREQ_BCR_RST 24'h000000

`endif

// ### core/dmareq_pkg.sv
// Types shared by the DMA request front end
package dmareq_pkg;

    typedef enum logic [1:0] {
        DMAREQ_IDLE = 2'b00,
        DMAREQ_STANDBY = 2'b01,
        DMAREQ_XFER = 2'b10
    } dmareq_chan_t;

    typedef struct packed {
        dmareq_chan_t [7:0] chan;
        logic [7:0][15:0] ccr;
        logic [7:0][23:0] bcr;
        logic [7:0] done;
        logic [7:0] cfgerr;
        logic [7:0] edge_pend;
        logic [7:0] prev_low;
        logic [7:0] ack_n;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [1:0] port_f_fn;
        logic [1:0] port_j_fn;
        logic [31:0] rdata;
        logic slverr;
    } dmareq_state_t;

endpackage : dmareq_pkg

// ### tb/dma_transfer_request_logic_tb.sv
// Self-checking bench for the DMA transfer request front end
`timescale 1ns/1ns
module dma_transfer_request_logic_tb;
    typedef struct {logic [11:0] base; logic [3:0] ccr; logic [31:0] cnt; int units;} dtrl_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic slv;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic prdy, perr;
    logic [7:0] interrupt_controller, breq, ack, gnt = 8'h00, done = 8'h00, r_interrupt_controller = 8'h00;
    logic [3:0] r_pin = 4'h0;
    logic [1:0] pf, pj;
    int fails = 0, total_checks = 0, n;
    dtrl_row_t rows [4];
    always #20 clk = ~clk;
    dmareq_core i_dmareq_core (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
        .o_pslverr(perr), .i_interrupt_controller_dma_request_n(interrupt_controller), .i_port_f_ext_dma_request_n(pf),
        .i_port_j_ext_dma_request_n(pj), .o_bus_request(breq), .i_bus_grant(gnt),
        .i_unit_done(done), .o_dma_acknowledge_n(ack));
    dtrl_req_model i_dtrl_req_model (.i_sys_clk(clk), .i_rst(rst), .i_raise_interrupt_controller(r_interrupt_controller),
        .i_raise_pin(r_pin), .i_dma_acknowledge_n(ack), .o_interrupt_controller_dma_request_n(interrupt_controller),
        .o_port_f_ext_dma_request_n(pf), .o_port_j_ext_dma_request_n(pj));
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %0h want %0h", $time, m, got, exp);
        end
    endtask : check
    task automatic give_up(input string m);
        fails++;
        $display("[FAIL] %0t timeout %s", $time, m);
        report_and_stop();
    endtask : give_up
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        if (n >= 20) give_up("apb");
        rd = prd;
        slv = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // Waits for the request, moves one unit, checks the acknowledge cycle
    task automatic unit(input int ch, input logic exp_ack);
        n = 0;
        while (breq[ch] !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) give_up("request");
        done[ch] <= 1'b1;
        gnt[ch] <= 1'b1;
        @(posedge clk);
        done[ch] <= 1'b0;
        gnt[ch] <= 1'b0;
        @(posedge clk);
        check(ack[ch], !exp_ack, "ack");
        if (!exp_ack) check(breq[ch], 1'b1, "held");
    endtask : unit
    task automatic pulse_pin(input logic [3:0] p);
        r_pin <= p;
        @(posedge clk);
        r_pin <= 4'h0;
    endtask : pulse_pin
    initial begin
        rows = '{'{12'h000, 4'h1, 32'h8, 2}, '{12'h010, 4'h9, 32'h4, 2},
            '{12'h040, 4'hD, 32'h3, 3}, '{12'h050, 4'h5, 32'h4, 1}};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(ack, 8'hFF, "ack reset");
        check(breq, 8'h00, "req reset");
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0, "count reset");
        apb(1'b0, 12'h0FC, 32'h0);
        check(slv, 1'b1, "unmapped");
        $display("Reset and decode test done");
        foreach (rows[r]) begin
            apb(1'b1, rows[r].base + 12'h004, rows[r].cnt);
            apb(1'b1, rows[r].base, {28'h0, rows[r].ccr});
            for (int u = 0; u < rows[r].units; u++)
                unit(rows[r].base[6:4], u == rows[r].units - 1);
            apb(1'b0, rows[r].base + 12'h008, 32'h0);
            check(rd, 32'h2, "done");
            $display("Internal row %0d done", r);
        end
        apb(1'b1, 12'h064, 32'h4);
        apb(1'b1, 12'h060, 32'h11);
        apb(1'b0, 12'h068, 32'h0);
        check(rd, 32'h4, "cfg error");
        apb(1'b1, 12'h074, 32'h2);
        apb(1'b1, 12'h070, 32'h1F);
        apb(1'b0, 12'h078, 32'h0);
        check(rd, 32'h9, "standby");
        check(breq[7], 1'b0, "no request yet");
        // A stale second transfer may start here, which the loop tolerates
        for (int u = 0; u < 2; u++) begin
            r_interrupt_controller[7] <= 1'b1;
            @(posedge clk);
            r_interrupt_controller[7] <= 1'b0;
            unit(7, 1'b1);
        end
        $display("Controller test done");
        apb(1'b1, 12'h080, 32'h1);
        apb(1'b1, 12'h024, 32'h2);
        apb(1'b1, 12'h020, 32'h3F);
        for (int u = 0; u < 2; u++) begin
            pulse_pin(4'h1);
            repeat (3) @(posedge clk);
            check(breq[2], 1'b0, "sync delay");
            unit(2, 1'b1);
            repeat (6) @(posedge clk);
            check(breq[2], 1'b0, "no edge");
        end
        $display("Edge test done");
        apb(1'b1, 12'h080, 32'hA);
        apb(1'b1, 12'h034, 32'h2);
        apb(1'b1, 12'h030, 32'h102F);
        pulse_pin(4'h8);
        repeat (8) @(posedge clk);
        check(breq[3], 1'b0, "port F first");
        pulse_pin(4'h2);
        unit(3, 1'b0);
        unit(3, 1'b1);
        $display("Level test done");
        report_and_stop();
    end
endmodule : dma_transfer_request_logic_tb
bind dmareq_core dtrl_core_asserts #(.NUM_CH(NUM_CH)) i_dtrl_core_asserts (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_interrupt_controller_dma_request_n(i_interrupt_controller_dma_request_n),
    .i_port_f_ext_dma_request_n(i_port_f_ext_dma_request_n),
    .i_port_j_ext_dma_request_n(i_port_j_ext_dma_request_n), .o_bus_request(o_bus_request),
    .i_bus_grant(i_bus_grant), .i_unit_done(i_unit_done),
    .o_dma_acknowledge_n(o_dma_acknowledge_n));

// ### tb/dtrl_core_asserts.sv
// Port-level assertions for the DMA transfer request front end
`timescale 1ns/1ns
module dtrl_core_asserts #(
    parameter int NUM_CH = 8
) (
    // Clock, reset and APB
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Request sources
    input wire logic [7:0] i_interrupt_controller_dma_request_n,
    input wire logic [1:0] i_port_f_ext_dma_request_n,
    input wire logic [1:0] i_port_j_ext_dma_request_n,
    // Engine handshake and acknowledge
    input wire logic [7:0] o_bus_request,
    input wire logic [7:0] i_bus_grant,
    input wire logic [7:0] i_unit_done,
    input wire logic [7:0] o_dma_acknowledge_n
);
    logic wr_acc;
    logic [7:0] gnt_done;
    logic [1:0] pin_low;
    assign wr_acc = i_psel & i_penable & i_pwrite;
    assign gnt_done = i_unit_done & i_bus_grant;
    // Either port may be routed, so a low on either is a candidate cause
    assign pin_low = ~i_port_f_ext_dma_request_n | ~i_port_j_ext_dma_request_n;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    a_slverr_phase: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("slave error outside access");
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        a_ack_single: assert property (!o_dma_acknowledge_n[i] |=> o_dma_acknowledge_n[i])
            else $error("acknowledge too long");
        a_ack_cause: assert property (!o_dma_acknowledge_n[i] |-> $past(gnt_done[i]))
            else $error("acknowledge without unit");
        a_ack_in_xfer: assert property (!o_dma_acknowledge_n[i] |-> $past(o_bus_request[i]))
            else $error("acknowledge outside transfer");
        a_breq_hold: assert property ($fell(o_bus_request[i]) |-> $past(gnt_done[i]) || $past(wr_acc))
            else $error("request dropped early");
        a_int_no_io: assert property (wr_acc && i_paddr[11:4] == 8'(i) && i_paddr[3:0] == 4'h0
            && i_pwdata[4] && !i_pwdata[1] && !o_bus_request[i] |=> !o_bus_request[i] [*3])
            else $error("internal I/O start");
        if (i != 2 && i != 3) begin : g_ctl
            a_breq_cause: assert property ($rose(o_bus_request[i])
                |-> $past(wr_acc) || !$past(i_interrupt_controller_dma_request_n[i]))
                else $error("request without cause");
        end else begin : g_pin
            a_pin_synced: assert property ($rose(o_bus_request[i]) |-> $past(wr_acc)
                || !$past(i_interrupt_controller_dma_request_n[i]) || $past(pin_low[i - 2], 3))
                else $error("pin request too early");
        end
    end
endmodule : dtrl_core_asserts

// ### tb/dtrl_req_model.sv
// Controller and pin requesters facing the DMA request front end
`timescale 1ns/1ns
module dtrl_req_model (
    // Clock, reset, bench pulses and acknowledge
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_raise_interrupt_controller,
    input wire logic [3:0] i_raise_pin,
    input wire logic [7:0] i_dma_acknowledge_n,
    // Request lines, pulled up when released
    output logic [7:0] o_interrupt_controller_dma_request_n,
    output logic [1:0] o_port_f_ext_dma_request_n,
    output logic [1:0] o_port_j_ext_dma_request_n
);
    logic [3:0] pin_n;
    logic [3:0] pin_ack;
    // Pin 0 serves channel 2 and pin 1 channel 3, on either port
    assign pin_ack = ~{i_dma_acknowledge_n[3:2], i_dma_acknowledge_n[3:2]};
    assign o_port_f_ext_dma_request_n = pin_n[1:0];
    assign o_port_j_ext_dma_request_n = pin_n[3:2];
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_interrupt_controller_dma_request_n <= 8'hFF;
            pin_n <= 4'hF;
        end else begin
            // Held until acknowledged, then released so a new request is a fresh edge
            o_interrupt_controller_dma_request_n <= (o_interrupt_controller_dma_request_n | ~i_dma_acknowledge_n) & ~i_raise_interrupt_controller;
            pin_n <= (pin_n | pin_ack) & ~i_raise_pin;
        end
    end
endmodule : dtrl_req_model
